// [sim/cbrl_prog_model.sv]
// Programmer and in-system programming model facing the option loader.
// Assumes it drives its ports just after clk_i rises, one request a call.
`timescale 1ns/1ps
`default_nettype none
module cbrl_prog_model #(
  parameter logic [7:0] STORE_VAL = 8'hA5
) (
  // Clock
  input wire logic clk_i,
  // Programming port
  output logic prog_o,
  output logic isp_o,
  output logic [1:0] sel_o,
  output logic [7:0] data_o,
  output logic erase_o,
  // Read port
  output logic rd_o,
  output logic rd_opt_o,
  output logic [7:0] store_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    prog_o = 1'b0;
    isp_o = 1'b0;
    sel_o = 2'h0;
    data_o = 8'h00;
    erase_o = 1'b0;
    rd_o = 1'b0;
    rd_opt_o = 1'b0;
  end
  // Inverse outside reads so stale data never passes
  assign store_o = rd_o ? STORE_VAL : ~STORE_VAL;
  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  // option write, reserved blank
  task automatic write_opt(input logic [1:0] sel, input logic [7:0] val, input logic isp);
    sel_o = sel;
    data_o = val | ((sel == cbrl_pkg::CBRL_SEL_OPT0) ? cbrl_pkg::CBRL_OPT0_RSVD
                                                     : cbrl_pkg::CBRL_OPT2_RSVD);
    isp_o = isp;
    prog_o = 1'b1;
    @(posedge clk_i);
    #1;
    prog_o = 1'b0;
    isp_o = 1'b0;
    data_o = ~data_o;
  endtask : write_opt
  task automatic read(input logic [1:0] sel, input logic opt);
    sel_o = sel;
    rd_opt_o = opt;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
  endtask : read
  task automatic erase;
    erase_o = 1'b1;
    @(posedge clk_i);
    #1;
    erase_o = 1'b0;
  endtask : erase
endmodule : cbrl_prog_model
`default_nettype wire

// [sim/tb_config_byte_reset_loader.sv]
// Self-checking bench for the option loader.
// Assumes the loader and a programmer model on one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module tb_config_byte_reset_loader;
  localparam logic [7:0] STORE = 8'hA5;
  logic clk_i, rstn_i, hw_reset_i, sw_reset_i, prog_i, isp_i, erase_i, refused;
  logic rd_i, rd_opt_i, rd_valid, boot_sel_wr_i, boot_sel_wdata_i, bod_wr_i;
  logic [1:0] sel, bod_lvl;
  logic [3:0] bod_wdata_i;
  logic [7:0] pdata, sdata, rdata, opt0, opt2;
  logic boot_sel, from_ldr, tbl_lock, bod_en, bod_rst, rel;
  int num_errors, n_compared;
  cbrl_prog_model #(.STORE_VAL(STORE)) u_prog (.clk_i(clk_i), .prog_o(prog_i),
    .isp_o(isp_i), .sel_o(sel), .data_o(pdata), .erase_o(erase_i), .rd_o(rd_i),
    .rd_opt_o(rd_opt_i), .store_o(sdata));
  cbrl_loader DUT (.clk_i(clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i),
    .sw_reset_i(sw_reset_i), .prog_i(prog_i), .isp_i(isp_i), .prog_sel_i(sel),
    .prog_data_i(pdata), .chip_erase_i(erase_i), .prog_refused_o(refused), .rd_i(rd_i),
    .rd_opt_i(rd_opt_i), .store_data_i(sdata), .rd_data_o(rdata), .rd_valid_o(rd_valid),
    .boot_sel_wr_i(boot_sel_wr_i), .boot_sel_wdata_i(boot_sel_wdata_i), .bod_wr_i(bod_wr_i),
    .bod_wdata_i(bod_wdata_i), .boot_select_control_o(boot_sel),
    .boot_from_loader_o(from_ldr), .table_read_lock_o(tbl_lock),
    .brownout_detect_enable_o(bod_en), .brownout_level_o(bod_lvl),
    .brownout_reset_enable_o(bod_rst), .core_release_o(rel),
    .boot_security_options_o(opt0), .brownout_options_o(opt2));
  always #2.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Bounded wait, a hang ends the run
  task automatic wait_rel;
    int n;
    n = 0;
    while (rel !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n >= 20) begin
      $display("mismatch at %0t: core never released", $time);
      num_errors++;
      wrap_up();
    end
  endtask : wait_rel
  task automatic reset_evt(input logic sw);
    hw_reset_i = ~sw;
    sw_reset_i = sw;
    tick(1);
    hw_reset_i = 1'b0;
    sw_reset_i = 1'b0;
    `CHK(rel, 1'b0, "core not held")
    wait_rel();
  endtask : reset_evt
  task automatic check_ctl(input logic [7:0] o0, input logic [7:0] o2, input logic bsel);
    `CHK(boot_sel, bsel, "boot select")
    `CHK(from_ldr, bsel, "boot store")
    `CHK(tbl_lock, ~o0[2], "table lock")
    `CHK(bod_en, o2[7], "bod enable")
    `CHK(bod_lvl, o2[6:5], "bod level")
    `CHK(bod_rst, o2[4], "bod reset")
  endtask : check_ctl
  task automatic rd_chk(input logic opt, input logic [1:0] s, input logic [7:0] exp);
    u_prog.read(s, opt);
    `CHK(rd_valid, 1'b1, "read valid")
    `CHK(rdata, exp, "read data")
    // Let an edge pass so back-to-back reads never retoggle the strobe at once
    tick(1);
    `CHK(rd_valid, 1'b0, "read valid pulse")
  endtask : rd_chk
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    {hw_reset_i, sw_reset_i, boot_sel_wr_i, boot_sel_wdata_i, bod_wr_i} = 5'h00;
    bod_wdata_i = 4'h0;
    num_errors = 0;
    n_compared = 0;
    tick(10);
    rstn_i = 1'b1;
    wait_rel();
    check_ctl(8'hFF, 8'hFF, 1'b0);
    `CHK(opt0, 8'hFF, "blank opt0")
    `CHK(opt2, 8'hFF, "blank opt2")
    $display("test blank done");
    u_prog.write_opt(cbrl_pkg::CBRL_SEL_OPT2, 8'h20, 1'b0);
    tick(1);
    u_prog.write_opt(cbrl_pkg::CBRL_SEL_OPT0, 8'h00, 1'b0);
    tick(2);
    `CHK(opt2, 8'h2F, "opt2 written")
    `CHK(opt0, 8'h79, "opt0 written")
    `CHK(bod_en, 1'b1, "copy before reset")
    reset_evt(1'b0);
    check_ctl(8'h79, 8'h2F, 1'b1);
    $display("test hard reload done");
    boot_sel_wr_i = 1'b1;
    boot_sel_wdata_i = 1'b0;
    bod_wr_i = 1'b1;
    bod_wdata_i = 4'hA;
    tick(1);
    {boot_sel_wr_i, bod_wr_i} = 2'h0;
    tick(1);
    `CHK(boot_sel, 1'b0, "boot select write")
    `CHK(({bod_en, bod_lvl, bod_rst}), 4'hA, "bod write")
    reset_evt(1'b1);
    check_ctl(8'h79, 8'h2F, 1'b0);
    // A write while the core is held must be dropped
    sw_reset_i = 1'b1;
    tick(1);
    sw_reset_i = 1'b0;
    boot_sel_wr_i = 1'b1;
    boot_sel_wdata_i = 1'b1;
    tick(1);
    boot_sel_wr_i = 1'b0;
    wait_rel();
    `CHK(boot_sel, 1'b0, "held write ignored")
    $display("test soft reload done");
    rd_chk(1'b0, cbrl_pkg::CBRL_SEL_OPT0, 8'hFF);
    rd_chk(1'b1, cbrl_pkg::CBRL_SEL_OPT0, 8'h79);
    rd_chk(1'b1, cbrl_pkg::CBRL_SEL_OPT2, 8'h2F);
    u_prog.write_opt(cbrl_pkg::CBRL_SEL_OPT2, 8'h00, 1'b0);
    `CHK(refused, 1'b1, "locked write")
    tick(2);
    `CHK(opt2, 8'h2F, "locked unchanged")
    u_prog.write_opt(cbrl_pkg::CBRL_SEL_OPT2, 8'h00, 1'b1);
    `CHK(refused, 1'b0, "isp write")
    tick(2);
    `CHK(opt2, 8'h0F, "isp applied")
    $display("test lock done");
    u_prog.erase();
    tick(2);
    `CHK(opt0, 8'hFF, "erase opt0")
    `CHK(opt2, 8'hFF, "erase opt2")
    rd_chk(1'b0, cbrl_pkg::CBRL_SEL_OPT0, STORE);
    reset_evt(1'b0);
    check_ctl(8'hFF, 8'hFF, 1'b0);
    $display("test erase done");
    wrap_up();
  end
endmodule : tb_config_byte_reset_loader
`default_nettype wire

// [verilog/cbrl_loader.sv]
// Option byte loader: copies option bits to control bits on reset events.
// Assumes reset event inputs are single-cycle pulses from the reset logic on clk_i,
// and the core stays in reset until core_release_o rises.
`timescale 1ns/1ps
`default_nettype none
module cbrl_loader #(
  parameter int LOAD_CYCLES = cbrl_pkg::CBRL_LOAD_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Reset events from the reset generator
  input wire logic hw_reset_i,
  input wire logic sw_reset_i,
  // Programming port
  input wire logic prog_i,
  input wire logic isp_i,
  input wire logic [1:0] prog_sel_i,
  input wire logic [7:0] prog_data_i,
  input wire logic chip_erase_i,
  output logic prog_refused_o,
  // Programmer read port
  input wire logic rd_i,
  input wire logic rd_opt_i,
  input wire logic [7:0] store_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Software control writes
  input wire logic boot_sel_wr_i,
  input wire logic boot_sel_wdata_i,
  input wire logic bod_wr_i,
  input wire logic [3:0] bod_wdata_i,
  // Control bits and outputs
  output logic boot_select_control_o,
  output logic boot_from_loader_o,
  output logic table_read_lock_o,
  output logic brownout_detect_enable_o,
  output logic [1:0] brownout_level_o,
  output logic brownout_reset_enable_o,
  output logic core_release_o,
  output logic [7:0] boot_security_options_o,
  output logic [7:0] brownout_options_o
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The load counter is two bits wide, so longer loads need a wider counter
  if (LOAD_CYCLES < 1 || LOAD_CYCLES > 4) begin : g_bad_load_cycles
    $error("LOAD_CYCLES must lie between 1 and 4");
  end

  // ----------------------------------------------------------------
  // Option storage and read path
  // ----------------------------------------------------------------
  logic [7:0] opt0;
  logic [7:0] opt2;
  logic [7:0] opt_rd;

  cbrl_option_store u_store (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .prog_i(prog_i),
    .isp_i(isp_i),
    .sel_i(prog_sel_i),
    .data_i(prog_data_i),
    .chip_erase_i(chip_erase_i),
    .opt0_o(opt0),
    .opt2_o(opt2),
    .refused_o(prog_refused_o)
  );

  assign opt_rd = (prog_sel_i == cbrl_pkg::CBRL_SEL_OPT2) ? opt2 : opt0;

  cbrl_read_gate u_rd (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .rd_i(rd_i),
    .rd_opt_i(rd_opt_i),
    .store_data_i(store_data_i),
    .opt_data_i(opt_rd),
    .chip_lock_bit_i(opt0[cbrl_pkg::CBRL_CHIP_LOCK_BIT]),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_security_options_o <= cbrl_pkg::CBRL_ERASED;
      brownout_options_o <= cbrl_pkg::CBRL_ERASED;
    end else begin
      boot_security_options_o <= opt0;
      brownout_options_o <= opt2;
    end
  end

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  cbrl_pkg::cbrl_state_t state_r;
  logic [1:0] cnt_r;
  logic sw_kind_r;
  logic load_now;

  assign load_now = (state_r == cbrl_pkg::CBRL_ST_LOAD) && (cnt_r == 2'h0);

  // Power-up counts as a full hardware reset load
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= cbrl_pkg::CBRL_ST_LOAD;
      cnt_r <= 2'(LOAD_CYCLES - 1);
      sw_kind_r <= 1'b0;
    end else if (hw_reset_i || sw_reset_i) begin
      // Hardware reset wins when both arrive together
      state_r <= cbrl_pkg::CBRL_ST_LOAD;
      cnt_r <= 2'(LOAD_CYCLES - 1);
      sw_kind_r <= sw_reset_i & ~hw_reset_i;
    end else begin
      case (state_r)
        cbrl_pkg::CBRL_ST_IDLE: begin
          state_r <= cbrl_pkg::CBRL_ST_IDLE;
        end
        cbrl_pkg::CBRL_ST_LOAD: begin
          if (cnt_r == 2'h0) begin
            state_r <= cbrl_pkg::CBRL_ST_DONE;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        cbrl_pkg::CBRL_ST_DONE: begin
          state_r <= cbrl_pkg::CBRL_ST_IDLE;
        end
        default: begin
          state_r <= cbrl_pkg::CBRL_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_release_o <= 1'b0;
    end else if (hw_reset_i || sw_reset_i) begin
      core_release_o <= 1'b0;
    end else if (state_r == cbrl_pkg::CBRL_ST_DONE) begin
      core_release_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control copies
  // ----------------------------------------------------------------
  // Boot select keeps its value over a software reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_select_control_o <= 1'b0;
    end else if (load_now && !sw_kind_r) begin
      boot_select_control_o <= ~opt0[cbrl_pkg::CBRL_BOOT_SRC_BIT];
    end else if (boot_sel_wr_i && core_release_o) begin
      boot_select_control_o <= boot_sel_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_from_loader_o <= 1'b0;
    end else if (state_r == cbrl_pkg::CBRL_ST_DONE) begin
      boot_from_loader_o <= boot_select_control_o;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      table_read_lock_o <= 1'b0;
    end else if (load_now) begin
      table_read_lock_o <= ~opt0[cbrl_pkg::CBRL_TBL_LOCK_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brownout_detect_enable_o <= 1'b1;
      brownout_level_o <= 2'h3;
      brownout_reset_enable_o <= 1'b1;
    end else if (load_now) begin
      brownout_detect_enable_o <= opt2[cbrl_pkg::CBRL_BOD_EN_BIT];
      brownout_level_o <= {opt2[cbrl_pkg::CBRL_BOD_LVL_HI_BIT],
                           opt2[cbrl_pkg::CBRL_BOD_LVL_LO_BIT]};
      brownout_reset_enable_o <= opt2[cbrl_pkg::CBRL_BOD_RST_BIT];
    end else if (bod_wr_i && core_release_o) begin
      brownout_detect_enable_o <= bod_wdata_i[3];
      brownout_level_o <= bod_wdata_i[2:1];
      brownout_reset_enable_o <= bod_wdata_i[0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // software reset keeps
  sw_keeps_bootsel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sw_reset_i && !hw_reset_i && !boot_sel_wr_i ##1 (!hw_reset_i && !boot_sel_wr_i)[*3]
    |-> $stable(boot_select_control_o))
    else $error("software reset changed boot select");
  hw_loads_bootsel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hw_reset_i && !sw_reset_i ##1 (!hw_reset_i && !sw_reset_i)[*2]
    |=> boot_select_control_o == ~$past(opt0[cbrl_pkg::CBRL_BOOT_SRC_BIT]))
    else $error("boot select not loaded from inverted option");
  release_after_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hw_reset_i || sw_reset_i) |=> !core_release_o ##0 !core_release_o [*3])
    else $error("core released before option load");
  release_holds_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    core_release_o && !hw_reset_i && !sw_reset_i |=> core_release_o)
    else $error("core release dropped without a reset");
  boot_uses_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == cbrl_pkg::CBRL_ST_DONE |=> boot_from_loader_o == $past(boot_select_control_o))
    else $error("boot store not taken from boot select");
  bod_loaded_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load_now |=> brownout_detect_enable_o == $past(opt2[7]) &&
    brownout_level_o == $past(opt2[6:5]) && brownout_reset_enable_o == $past(opt2[4]))
    else $error("brown-out controls not loaded");
  tbl_lock_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    load_now |=> table_read_lock_o == !$past(opt0[2]))
    else $error("table read lock wrong after load");
  sw_write_holds_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    boot_sel_wr_i && core_release_o && !load_now
    |=> boot_select_control_o == $past(boot_sel_wdata_i))
    else $error("software write to boot select lost");
  held_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    boot_sel_wr_i && !core_release_o && !load_now |=> $stable(boot_select_control_o))
    else $error("boot select written while core held");
  bod_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bod_wr_i && core_release_o && !load_now
    |=> {brownout_detect_enable_o, brownout_level_o, brownout_reset_enable_o}
        == $past(bod_wdata_i))
    else $error("software write to brown-out controls lost");

  sw_reset_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    sw_reset_i ##[1:4] core_release_o);
  hw_reset_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    hw_reset_i ##[1:4] core_release_o);
  locked_read_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && !opt0[1]);
  held_write_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    boot_sel_wr_i && !core_release_o);
  soft_write_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    boot_sel_wr_i && core_release_o);
endmodule : cbrl_loader
`default_nettype wire

// [verilog/cbrl_option_store.sv]
// Non-volatile option byte storage with programmer write and erase paths.
// Assumes program and erase requests are single-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module cbrl_option_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Programming requests
  input wire logic prog_i,
  input wire logic isp_i,
  input wire logic [1:0] sel_i,
  input wire logic [7:0] data_i,
  input wire logic chip_erase_i,
  // Stored bytes
  output logic [7:0] opt0_o,
  output logic [7:0] opt2_o,
  output logic refused_o
);
  logic locked;
  logic wr_ok;
  assign locked = ~opt0_o[cbrl_pkg::CBRL_CHIP_LOCK_BIT];
  assign wr_ok = prog_i & (isp_i | ~locked);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Reset models a blank part; real parts keep contents across resets.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opt0_o <= cbrl_pkg::CBRL_ERASED;
      opt2_o <= cbrl_pkg::CBRL_ERASED;
    end else if (chip_erase_i) begin
      opt0_o <= cbrl_pkg::CBRL_ERASED;
      opt2_o <= cbrl_pkg::CBRL_ERASED;
    end else if (wr_ok) begin
      if (sel_i == cbrl_pkg::CBRL_SEL_OPT0) begin
        opt0_o <= opt0_o & (data_i | cbrl_pkg::CBRL_OPT0_RSVD);
      end
      if (sel_i == cbrl_pkg::CBRL_SEL_OPT2) begin
        opt2_o <= opt2_o & (data_i | cbrl_pkg::CBRL_OPT2_RSVD);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      refused_o <= 1'b0;
    end else begin
      refused_o <= prog_i & ~isp_i & locked & ~chip_erase_i;
    end
  end

  refuse_when_locked_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    prog_i && !isp_i && locked && !chip_erase_i |=> refused_o && $stable(opt0_o))
    else $error("locked option byte was programmed");
  erase_unlocks_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    chip_erase_i |=> opt0_o == 8'hFF && opt2_o == 8'hFF)
    else $error("chip erase left option bits programmed");
endmodule : cbrl_option_store
`default_nettype wire

// [verilog/cbrl_pkg.sv]
// Constants for the option byte loader.
// Assumes one system clock and reset events delivered as single-cycle pulses.
`default_nettype none
package cbrl_pkg;
  // ----------------------------------------------------------------
  // Option byte layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CBRL_ERASED = 8'hFF;
  localparam logic [7:0] CBRL_READ_LOCKED = 8'hFF;
  localparam int CBRL_BOOT_SRC_BIT = 7;
  localparam int CBRL_TBL_LOCK_BIT = 2;
  localparam int CBRL_CHIP_LOCK_BIT = 1;
  localparam int CBRL_BOD_EN_BIT = 7;
  localparam int CBRL_BOD_LVL_HI_BIT = 6;
  localparam int CBRL_BOD_LVL_LO_BIT = 5;
  localparam int CBRL_BOD_RST_BIT = 4;
  // Reserved bits of each byte, forced to ones on write
  localparam logic [7:0] CBRL_OPT0_RSVD = 8'h79;
  localparam logic [7:0] CBRL_OPT2_RSVD = 8'h0F;
  // ----------------------------------------------------------------
  // Option byte selectors on the programming port
  // ----------------------------------------------------------------
  localparam logic [1:0] CBRL_SEL_OPT0 = 2'h0;
  localparam logic [1:0] CBRL_SEL_OPT2 = 2'h2;
  // Cycles the loader spends on the copy before releasing the core
  localparam int CBRL_LOAD_CYCLES = 2;
  typedef enum logic [1:0] {
    CBRL_ST_IDLE,
    CBRL_ST_LOAD,
    CBRL_ST_DONE
  } cbrl_state_t;
endpackage : cbrl_pkg
`default_nettype wire

// [verilog/cbrl_read_gate.sv]
// Programmer read path with chip lock masking.
// Assumes the store data arrives from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module cbrl_read_gate (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Read request
  input wire logic rd_i,
  input wire logic rd_opt_i,
  input wire logic [7:0] store_data_i,
  input wire logic [7:0] opt_data_i,
  input wire logic chip_lock_bit_i,
  // Answer
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= cbrl_pkg::CBRL_READ_LOCKED;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_i;
      if (rd_i) begin
        if (rd_opt_i) begin
          rd_data_o <= opt_data_i;
        end else if (!chip_lock_bit_i) begin
          rd_data_o <= cbrl_pkg::CBRL_READ_LOCKED;
        end else begin
          rd_data_o <= store_data_i;
        end
      end
    end
  end

  locked_read_ff_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && !rd_opt_i && !chip_lock_bit_i |=> rd_valid_o && rd_data_o == 8'hFF)
    else $error("locked store read returned contents");
endmodule : cbrl_read_gate
`default_nettype wire
